// [rtl/cid_core.sv]
// cpu subset core with apb register slave and event interrupt
//
// Design decision made here: the APB register port.
`timescale 1ns/100ps
`include "cid_consts.svh"
module cid_core (
    // clock and reset
    input  wire logic        clk_in,
    input  wire logic        resetn_in,
    // apb slave
    input  wire logic        psel_in,
    input  wire logic        penable_in,
    input  wire logic        pwrite_in,
    input  wire logic [7:0]  paddr_in,
    input  wire logic [31:0] pwdata_in,
    output logic      [31:0] prdata_out,
    output logic             pready_out,
    output logic             pslverr_out,
    // cpu memory bus
    output logic      [15:0] mem_addr_out,
    output logic      [7:0]  mem_wdata_out,
    output logic             mem_we_out,
    input  wire logic [7:0]  mem_rdata_in,
    // interrupt sources and event interrupt
    input  wire logic [7:0]  irq_src_in,
    output logic             irq_out
);
    import cid_pkg::*;

    cid_state_t  st;
    logic [15:0] pc;
    logic [7:0]  a, x, s, p, ir, opnd;
    logic [1:0]  cnt;
    logic [7:0]  irq_flags;
    logic [1:0]  ev_st, ev_mask;
    logic [7:0]  rd;
    logic        wr_acc, rd_set, mapped, t_mode;
    logic        ev_brk, ev_undef;
    logic [15:0] next_alu;

    assign rd     = mem_rdata_in;
    assign t_mode = p[`CID_BIT_T];

    function automatic logic [15:0] rel_pc(input logic [15:0] b,
                                           input logic [7:0] o);
        return b + {{8{o[7]}}, o};
    endfunction : rel_pc

    // bit branches: low nibble 3 or 7, bit in [7:5], [4]=1 tests clear
    function automatic logic is_bbx(input logic [7:0] op);
        return (op[3:0] == 4'h3) || (op[3:0] == 4'h7);
    endfunction : is_bbx

    function automatic logic br_ok(input logic [7:0] op,
                                   input logic [7:0] f);
        case (op)
            `CID_OP_BCC: return !f[`CID_BIT_C];
            `CID_OP_BCS: return f[`CID_BIT_C];
            `CID_OP_BEQ: return f[`CID_BIT_Z];
            `CID_OP_BNE: return !f[`CID_BIT_Z];
            `CID_OP_BMI: return f[`CID_BIT_N];
            `CID_OP_BPL: return !f[`CID_BIT_N];
            `CID_OP_BRA: return 1'b1;
            default:     return 1'b0;
        endcase
    endfunction : br_ok

    // returns {result, flags}; l is the destination side operand
    function automatic logic [15:0] alu(input logic [7:0] op,
        input logic [7:0] l, input logic [7:0] r, input logic [7:0] f);
        logic [8:0] sum;
        logic [7:0] res, nf;
        sum = {1'b0, l} + {1'b0, r} + {8'h00, f[`CID_BIT_C]};
        res = l;
        nf  = f;
        case (op)
            `CID_OP_ADCI, `CID_OP_ADCZ:
            begin
                res = sum[7:0];
                nf[`CID_BIT_V] = (l[7] == r[7]) && (sum[7] != l[7]);
                nf[`CID_BIT_C] = sum[8];
            end
            `CID_OP_ANDI, `CID_OP_ANDZ:
                res = l & r;
            `CID_OP_ASLA, `CID_OP_ASLZ:
            begin
                res = {l[6:0], 1'b0};
                nf[`CID_BIT_C] = l[7];
            end
            default:
            begin
                nf[`CID_BIT_N] = r[7];
                nf[`CID_BIT_V] = r[6];
            end
        endcase
        if (op == `CID_OP_BITZ || op == `CID_OP_BITA)
            nf[`CID_BIT_Z] = ((l & r) == 8'h00);
        else
        begin
            nf[`CID_BIT_N] = res[7];
            nf[`CID_BIT_Z] = (res == 8'h00);
        end
        return {res, nf};
    endfunction : alu

    function automatic logic needs_opr(input logic [7:0] op);
        case (op)
            `CID_OP_ADCI, `CID_OP_ADCZ, `CID_OP_ANDI, `CID_OP_ANDZ,
            `CID_OP_ASLZ, `CID_OP_BITZ, `CID_OP_BITA, `CID_OP_BCC,
            `CID_OP_BCS, `CID_OP_BEQ, `CID_OP_BNE, `CID_OP_BMI,
            `CID_OP_BPL, `CID_OP_BRA: return 1'b1;
            default: return is_bbx(op);
        endcase
    endfunction : needs_opr

    assign ev_brk   = (st == st_dec) && (rd == `CID_OP_BRK);
    assign ev_undef = (st == st_dec) && !needs_opr(rd)
                      && rd != `CID_OP_BRK && rd != `CID_OP_ASLA
                      && rd != `CID_OP_CLT && rd != `CID_OP_SET
                      && rd != `CID_OP_NOP;

    // operand fed to the alu depends on the state that consumes it
    always_comb
    begin
        case (st)
            st_mx:   next_alu = alu(ir, rd, opnd, p);
            st_mem:  next_alu = (ir == `CID_OP_ASLZ) ?
                                alu(ir, rd, 8'h00, p) : alu(ir, a, rd, p);
            st_dec:  next_alu = alu(rd, a, 8'h00, p);
            default: next_alu = alu(ir, a, rd, p);
        endcase
    end

    // instruction sequencer
    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            st <= st_fetch;
            pc <= `CID_RST_PC;
            a <= 8'h00;
            s <= `CID_RST_S;
            p <= `CID_RST_P;
            ir <= 8'h00;
            opnd <= 8'h00;
            cnt <= 2'h0;
            mem_addr_out <= 16'h0000;
            mem_wdata_out <= 8'h00;
            mem_we_out <= 1'b0;
        end
        else
        begin
            mem_we_out <= 1'b0;
            case (st)
                st_fetch:
                begin
                    mem_addr_out <= pc;
                    pc <= pc + 16'h0001;
                    st <= st_dec;
                end
                st_dec:
                begin
                    ir <= rd;
                    st <= st_fetch;
                    if (rd == `CID_OP_BRK)
                    begin
                        p[`CID_BIT_B] <= 1'b1;
                        cnt <= 2'h0;
                        st <= st_push;
                    end
                    else if (rd == `CID_OP_ASLA)
                        {a, p} <= next_alu;
                    else if (rd == `CID_OP_CLT)
                        p[`CID_BIT_T] <= 1'b0;
                    else if (rd == `CID_OP_SET)
                        p[`CID_BIT_T] <= 1'b1;
                    else if (needs_opr(rd))
                    begin
                        mem_addr_out <= pc;
                        pc <= pc + 16'h0001;
                        st <= st_opr;
                    end
                end
                st_opr:
                begin
                    opnd <= rd;
                    st <= st_fetch;
                    if (ir == `CID_OP_ADCI || ir == `CID_OP_ANDI)
                    begin
                        if (t_mode)
                        begin
                            mem_addr_out <= {8'h00, x};
                            st <= st_mx;
                        end
                        else
                            {a, p} <= next_alu;
                    end
                    else if (ir == `CID_OP_BITA)
                    begin
                        mem_addr_out <= pc;
                        pc <= pc + 16'h0001;
                        st <= st_abs;
                    end
                    else if (ir[3:0] == 4'h3)
                    begin
                        if (a[ir[7:5]] != ir[4])
                            pc <= rel_pc(pc, rd);
                    end
                    else if (is_bbx(ir) || ir[3:0] == 4'h5
                             || ir[3:0] == 4'h6 || ir[3:0] == 4'h4)
                    begin
                        mem_addr_out <= {8'h00, rd};
                        st <= st_mem;
                    end
                    else if (br_ok(ir, p))
                        pc <= rel_pc(pc, rd);
                end
                st_abs:
                begin
                    mem_addr_out <= {rd, opnd};
                    st <= st_mem;
                end
                st_mem:
                begin
                    st <= st_fetch;
                    if (ir == `CID_OP_ASLZ)
                    begin
                        mem_wdata_out <= next_alu[15:8];
                        mem_we_out <= 1'b1;
                        p <= next_alu[7:0];
                    end
                    else if (is_bbx(ir))
                    begin
                        opnd <= rd;
                        mem_addr_out <= pc;
                        pc <= pc + 16'h0001;
                        st <= st_rel;
                    end
                    else if (ir == `CID_OP_BITZ || ir == `CID_OP_BITA)
                        p <= next_alu[7:0];
                    else if (t_mode)
                    begin
                        opnd <= rd;
                        mem_addr_out <= {8'h00, x};
                        st <= st_mx;
                    end
                    else
                        {a, p} <= next_alu;
                end
                st_mx:
                begin
                    mem_wdata_out <= next_alu[15:8];
                    mem_we_out <= 1'b1;
                    p <= next_alu[7:0];
                    st <= st_fetch;
                end
                st_rel:
                begin
                    if (opnd[ir[7:5]] != ir[4])
                        pc <= rel_pc(pc, rd);
                    st <= st_fetch;
                end
                st_push:
                begin
                    mem_addr_out <= {`CID_STACK_HI, s};
                    mem_we_out <= 1'b1;
                    s <= s - 8'h01;
                    cnt <= cnt + 2'h1;
                    case (cnt)
                        2'h0:    mem_wdata_out <= pc[15:8];
                        2'h1:    mem_wdata_out <= pc[7:0];
                        default: mem_wdata_out <= p;
                    endcase
                    if (cnt == 2'h2)
                        st <= st_vec1;
                end
                st_vec1:
                begin
                    mem_addr_out <= `CID_VEC_LO;
                    st <= st_vec2;
                end
                st_vec2:
                begin
                    if (mem_addr_out == `CID_VEC_LO)
                    begin
                        pc[7:0] <= rd;
                        mem_addr_out <= `CID_VEC_HI;
                    end
                    else
                    begin
                        pc[15:8] <= rd;
                        p[`CID_BIT_I] <= 1'b1;
                        st <= st_fetch;
                    end
                end
                default: st <= st_fetch;
            endcase
        end
    end

    // apb decode; zero wait states, read data caught in setup
    assign pready_out = 1'b1;
    assign wr_acc = psel_in && penable_in && pwrite_in;
    assign rd_set = psel_in && !penable_in && !pwrite_in;
    assign mapped = paddr_in == `CID_OFF_IRQF
                    || paddr_in == `CID_OFF_EVST
                    || paddr_in == `CID_OFF_EVMSK
                    || paddr_in == `CID_OFF_STATE
                    || paddr_in == `CID_OFF_XREG;
    assign pslverr_out = psel_in && penable_in && !mapped;

    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
            prdata_out <= 32'h0000_0000;
        else if (rd_set)
        begin
            case (paddr_in)
                `CID_OFF_IRQF:  prdata_out <= {24'h000000, irq_flags};
                `CID_OFF_EVST:  prdata_out <= {30'h00000000, ev_st};
                `CID_OFF_EVMSK: prdata_out <= {30'h00000000, ev_mask};
                `CID_OFF_STATE: prdata_out <= {pc, a, p};
                `CID_OFF_XREG:  prdata_out <= {24'h000000, x};
                default:        prdata_out <= 32'h0000_0000;
            endcase
        end
    end

    // request flags: a source pulse wins over a software clear
    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
            irq_flags <= `CID_RST_IRQF;
        else if (wr_acc && paddr_in == `CID_OFF_IRQF)
            irq_flags <= (irq_flags & pwdata_in[7:0]) | irq_src_in;
        else
            irq_flags <= irq_flags | irq_src_in;
    end

    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
            x <= 8'h00;
        else if (wr_acc && paddr_in == `CID_OFF_XREG)
            x <= pwdata_in[7:0];
    end

    // event status, write one to clear, set wins
    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            ev_st <= 2'h0;
            ev_mask <= 2'h0;
        end
        else
        begin
            if (wr_acc && paddr_in == `CID_OFF_EVST)
                ev_st <= (ev_st & ~pwdata_in[1:0]) | {ev_undef, ev_brk};
            else
                ev_st <= ev_st | {ev_undef, ev_brk};
            if (wr_acc && paddr_in == `CID_OFF_EVMSK)
                ev_mask <= pwdata_in[1:0];
        end
    end

    assign irq_out = |(ev_st & ev_mask);

    default clocking @(posedge clk_in); endclocking
    default disable iff (!resetn_in);

    adc_acc_a: assert property (st == st_opr && ir == `CID_OP_ADCI
        && !t_mode |=> a == $past(a + rd + {7'h00, p[0]}))
        else $error("adc result wrong");
    and_flags_a: assert property (st == st_opr && ir == `CID_OP_ANDI
        && !t_mode |=> a == $past(a & rd) && p[6] == $past(p[6])
        && p[0] == $past(p[0]))
        else $error("and result or flags wrong");
    asl_acc_a: assert property (st == st_dec && rd == `CID_OP_ASLA
        |=> a == {$past(a[6:0]), 1'b0} && p[0] == $past(a[7]))
        else $error("shift left wrong");
    bbx_flags_a: assert property (st == st_rel |=> $stable(p))
        else $error("bit branch changed flags");
    cond_branch_a: assert property (st == st_opr
        && ir[3:0] == 4'h0 && ir[4:0] != 5'h00 |=> $stable(p)
        && pc == ($past(br_ok(ir, p)) ? $past(rel_pc(pc, rd))
                                      : $past(pc)))
        else $error("relative branch wrong");
    bit_test_a: assert property (st == st_mem && ir == `CID_OP_BITZ
        |=> $stable(a) && p[7] == $past(rd[7]) && p[6] == $past(rd[6]))
        else $error("bit test wrong");
    brk_push_a: assert property (st == st_dec && rd == `CID_OP_BRK
        |=> ##1 mem_we_out && mem_wdata_out == $past(pc[15:8], 2)
        ##1 mem_wdata_out == $past(pc[7:0], 3)
        ##1 mem_wdata_out[4] ##4 p[2])
        else $error("software interrupt sequence wrong");
    flag_zero_set_a: assert property (wr_acc
        && paddr_in == `CID_OFF_IRQF && irq_src_in == 8'h00
        |=> irq_flags == $past(irq_flags & pwdata_in[7:0]))
        else $error("request flag write wrong");
    undef_nop_a: assert property (ev_undef
        |=> st == st_fetch && $stable(a) && $stable(pc))
        else $error("undefined opcode not a no-operation");
    src_set_a: assert property (|irq_src_in
        |=> (irq_flags & $past(irq_src_in)) == $past(irq_src_in))
        else $error("request flag not set");

    brk_seen_c: cover property (ev_brk ##[1:10] st == st_fetch);
    taken_c: cover property (st == st_opr && br_ok(ir, p));
    tmode_c: cover property (st == st_mx ##1 mem_we_out);
    irq_c: cover property (irq_out);
endmodule : cid_core

// [rtl/cid_consts.svh]
// constants of the instruction decode and execute block
`ifndef CID_CONSTS_SVH
`define CID_CONSTS_SVH
`define CID_OFF_IRQF  8'h3c
`define CID_OFF_EVST  8'h40
`define CID_OFF_EVMSK 8'h44
`define CID_OFF_STATE 8'h48
`define CID_OFF_XREG  8'h4c
`define CID_RST_IRQF  8'h00
`define CID_RST_P     8'h04
`define CID_RST_S     8'hff
`define CID_RST_PC    16'h0000
`define CID_VEC_LO    16'hfffe
`define CID_VEC_HI    16'hffff
`define CID_STACK_HI  8'h01
`define CID_BIT_N     7
`define CID_BIT_V     6
`define CID_BIT_T     5
`define CID_BIT_B     4
`define CID_BIT_I     2
`define CID_BIT_Z     1
`define CID_BIT_C     0
`define CID_OP_BRK    8'h00
`define CID_OP_ADCI   8'h69
`define CID_OP_ADCZ   8'h65
`define CID_OP_ANDI   8'h29
`define CID_OP_ANDZ   8'h25
`define CID_OP_ASLA   8'h0a
`define CID_OP_ASLZ   8'h06
`define CID_OP_BITZ   8'h24
`define CID_OP_BITA   8'h2c
`define CID_OP_BCC    8'h90
`define CID_OP_BCS    8'hb0
`define CID_OP_BEQ    8'hf0
`define CID_OP_BNE    8'hd0
`define CID_OP_BMI    8'h30
`define CID_OP_BPL    8'h10
`define CID_OP_BRA    8'h80
`define CID_OP_CLT    8'h12
`define CID_OP_SET    8'h32
`define CID_OP_NOP    8'hea
`endif

// [rtl/cid_pkg.sv]
// types of the instruction decode and execute block
package cid_pkg;
    typedef enum logic [3:0] {
        st_fetch = 4'h0,
        st_dec   = 4'h1,
        st_opr   = 4'h2,
        st_abs   = 4'h3,
        st_mem   = 4'h4,
        st_mx    = 4'h5,
        st_rel   = 4'h6,
        st_push  = 4'h7,
        st_vec1  = 4'h8,
        st_vec2  = 4'h9
    } cid_state_t;
endpackage : cid_pkg

// [bench/cid_mem.sv]
// program and data memory model on the cpu bus
`timescale 1ns/100ps
module cid_mem (
    // cpu bus
    input  wire logic        clk_in,
    input  wire logic [15:0] addr_in,
    input  wire logic [7:0]  wdata_in,
    input  wire logic        we_in,
    output logic      [7:0]  rdata_out
);
    logic [7:0] m [0:65535];
    // zeroed so that no read is left to the simulator
    initial
    begin
        for (int i = 0; i < 65536; i++)
            m[i] = 8'h00;
    end
    always @(posedge clk_in)
    begin
        if (we_in)
            m[addr_in] <= wdata_in;
    end
    // combinational read of the registered address, answer in the same cycle
    assign rdata_out = m[addr_in];
endmodule : cid_mem

// [bench/cpu_instruction_decode_exec_tb.sv]
// self-checking testbench of the decode and execute core
`timescale 1ns/100ps
`include "cid_consts.svh"
module cpu_instruction_decode_exec_tb;
    logic        clk_in = 1'b0;
    logic        resetn_in = 1'b0;
    logic        psel_in = 1'b0;
    logic        penable_in = 1'b0;
    logic        pwrite_in = 1'b0;
    logic [7:0]  paddr_in = 8'h00;
    logic [31:0] pwdata_in = 32'h0;
    logic [31:0] prdata_out;
    logic        pready_out;
    logic        pslverr_out;
    logic [15:0] mem_addr_out;
    logic [7:0]  mem_wdata_out;
    logic        mem_we_out;
    logic [7:0]  mem_rdata_in;
    logic [7:0]  irq_src_in = 8'h00;
    logic        irq_out;
    integer      fail_count = 0;
    integer      n_tests = 0;
    logic [31:0] seed = 32'hacf52aaf;
    logic [31:0] rd;
    logic        er;
    logic [7:0]  flags;
    logic [7:0]  v;
    // traps of 69 ff sit where a wrong branch would land
    logic [7:0]  prog [0:40] = '{8'h69, 8'h55, 8'h29, 8'h0f, 8'h0a,
        8'h32, 8'h69, 8'h03, 8'h12, 8'h06, 8'h80, 8'hb0, 8'h02, 8'h90,
        8'h02, 8'h69, 8'hff, 8'h24, 8'h81, 8'hf0, 8'h02, 8'h69, 8'hff,
        8'h30, 8'h02, 8'h69, 8'hff, 8'hd0, 8'h04, 8'h10, 8'h02, 8'h23,
        8'h02, 8'h69, 8'hff, 8'h13, 8'h02, 8'h69, 8'hff, 8'h04, 8'h00};

    always #12.5 clk_in = ~clk_in;

    cid_core uut (
        .clk_in        (clk_in),
        .resetn_in     (resetn_in),
        .psel_in       (psel_in),
        .penable_in    (penable_in),
        .pwrite_in     (pwrite_in),
        .paddr_in      (paddr_in),
        .pwdata_in     (pwdata_in),
        .prdata_out    (prdata_out),
        .pready_out    (pready_out),
        .pslverr_out   (pslverr_out),
        .mem_addr_out  (mem_addr_out),
        .mem_wdata_out (mem_wdata_out),
        .mem_we_out    (mem_we_out),
        .mem_rdata_in  (mem_rdata_in),
        .irq_src_in    (irq_src_in),
        .irq_out       (irq_out)
    );
    cid_mem mem (
        .clk_in    (clk_in),
        .addr_in   (mem_addr_out),
        .wdata_in  (mem_wdata_out),
        .we_in     (mem_we_out),
        .rdata_out (mem_rdata_in)
    );

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    task automatic end_of_test;
        if (fail_count == 0 && n_tests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : end_of_test

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
            fail_count++;
        end
    endtask : chk

    // one apb transfer; the master never assumes the wait length
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int i;
        @(posedge clk_in);
        psel_in <= 1'b1;
        pwrite_in <= w;
        paddr_in <= a;
        pwdata_in <= d;
        @(posedge clk_in);
        penable_in <= 1'b1;
        i = 0;
        @(posedge clk_in);
        while (pready_out !== 1'b1)
        begin
            i++;
            if (i > 20)
            begin
                fail_count++;
                end_of_test();
            end
            @(posedge clk_in);
        end
        rd = prdata_out;
        er = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
    endtask : apb

    initial
    begin
        #1;
        for (int i = 0; i < 41; i++)
            mem.m[i] = prog[i];
        mem.m[16'h0080] = 8'h10;
        mem.m[16'h0081] = 8'hc0;
        mem.m[16'hfffe] = 8'h40;
        mem.m[16'h0040] = 8'h80;
        mem.m[16'h0041] = 8'hfe;
        repeat (5) @(posedge clk_in);
        resetn_in <= 1'b1;
        // x must be loaded before the t-mode add, a few cycles in
        apb(1'b1, `CID_OFF_XREG, 32'h80);
        apb(1'b0, `CID_OFF_IRQF, 32'h0);
        chk(rd, 32'h0);
        flags = 8'h00;
        for (int k = 0; k < 6; k++)
        begin
            v = seed[7:0];
            seed = lfsr(seed);
            irq_src_in <= v;
            @(posedge clk_in);
            irq_src_in <= 8'h00;
            flags = flags | v;
            apb(1'b0, `CID_OFF_IRQF, 32'h0);
            chk(rd, {24'h0, flags});
            v = seed[7:0];
            seed = lfsr(seed);
            apb(1'b1, `CID_OFF_IRQF, {seed[31:8], v});
            flags = flags & v;
            apb(1'b0, `CID_OFF_IRQF, 32'h0);
            chk(rd, {24'h0, flags});
        end
        for (int i = 0; i <= 300 && mem_addr_out !== 16'h0040; i++)
        begin
            if (i == 300)
            begin
                fail_count++;
                end_of_test();
            end
            @(posedge clk_in);
        end
        repeat (8) @(posedge clk_in);
        chk(mem.m[16'h0080], 8'h26);
        chk(mem.m[16'h01ff], 8'h00);
        chk(mem.m[16'h01fe], 8'h29);
        chk(mem.m[16'h01fd], 8'hd6);
        apb(1'b0, `CID_OFF_STATE, 32'h0);
        // a, then p with n v z from the bit test and b i from the trap
        chk(rd[15:0], 16'h0ad6);
        apb(1'b1, `CID_OFF_STATE, 32'h0);
        apb(1'b0, `CID_OFF_STATE, 32'h0);
        chk(rd[15:0], 16'h0ad6);
        apb(1'b0, `CID_OFF_EVST, 32'h0);
        chk(rd, 32'h3);
        chk(irq_out, 1'b0);
        apb(1'b1, `CID_OFF_EVMSK, 32'h2);
        #1;
        chk(irq_out, 1'b1);
        apb(1'b1, `CID_OFF_EVST, 32'h2);
        #1;
        chk(irq_out, 1'b0);
        apb(1'b0, `CID_OFF_EVST, 32'h0);
        chk(rd, 32'h1);
        apb(1'b0, `CID_OFF_EVMSK, 32'h0);
        chk(rd, 32'h2);
        apb(1'b0, 8'h50, 32'h0);
        chk({31'h0, er}, 32'h1);
        chk(rd, 32'h0);
        end_of_test();
    end
endmodule : cpu_instruction_decode_exec_tb
